// ==== guard_pkg.sv ====
// constants shared by the communication-loss watchdog
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus

package guard_pkg;

   // ------------------------------------------------------------
   // bus shape
   // ------------------------------------------------------------
   localparam int ADR_W = 18;
   localparam int IDX_W = 16;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_ENABLE = 16'hf0a0;
   localparam logic [IDX_W-1:0] IDX_ADVANCED = 16'hf0a2;
   localparam logic [IDX_W-1:0] IDX_TIMEOUT = 16'hf0a4;
   localparam logic [IDX_W-1:0] IDX_STRICT_ENABLE = 16'hf0aa;
   localparam logic [IDX_W-1:0] IDX_STRICT_KEY = 16'hf0ac;
   localparam logic [IDX_W-1:0] IDX_STRICT_CLEAR = 16'hf0ae;
   localparam logic [IDX_W-1:0] IDX_RESET_ACTION = 16'hf0b4;
   localparam logic [IDX_W-1:0] IDX_DIGITAL_ACTION = 16'hf0be;
   localparam logic [IDX_W-1:0] IDX_DIGITAL_LEVEL = 16'hf0c0;
   localparam logic [IDX_W-1:0] IDX_DIGITAL_DIRECTION = 16'hf0c2;
   localparam logic [IDX_W-1:0] IDX_DIGITAL_MASK = 16'hf0c4;
   localparam logic [IDX_W-1:0] IDX_ANALOG0_ACTION = 16'hf0c8;
   localparam logic [IDX_W-1:0] IDX_ANALOG0_VOLTAGE = 16'hf0ca;
   localparam logic [IDX_W-1:0] IDX_ANALOG1_ACTION = 16'hf0d2;
   localparam logic [IDX_W-1:0] IDX_ANALOG1_VOLTAGE = 16'hf0d4;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hf0e0;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hf0e2;
   localparam logic [IDX_W-1:0] IDX_STATE = 16'hf0e4;
   localparam logic [IDX_W-1:0] IDX_ELAPSED = 16'hf0e6;

   // ------------------------------------------------------------
   // values and fields
   // ------------------------------------------------------------
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] ACTION_ON = 32'h0000_0001;
   localparam int ADV_FACTORY_BIT = 0;
   localparam int ADV_SAVED_BIT = 1;
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_KEY_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int STATE_ARMED_BIT = 0;
   localparam int STATE_STRICT_BIT = 1;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_S = 1_000_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = TICK_PERIOD_S * NS_PER_S / CLK_PERIOD_NS;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_RESET = 1'b1
   } seq_state_t;

endpackage

// ==== comm_loss_watchdog.sv ====
// communication-loss watchdog: seconds timer, clear sources, timeout actions
// assumes comm_seen_i and response_sent_i are one-cycle pulses on clk_i
//
// Function
// - enable register holding 1 arms the watchdog
// - any received communication clears the timer outside strict
// - expiry after timeout seconds runs enabled actions
// - sending a response restarts timeout outside strict
// - reset action register 1 resets device
// - digital action register 1 updates digital lines
// - lines driven to stored timeout levels
// - lines set to stored timeout directions
// - lines selected in mask stay untouched
// - analog output 0 loads stored voltage
// - analog output 1 loads stored voltage
// - advanced bit 0 reloads factory setup
// - advanced bit 1 reloads saved setup
// - strict mode ignores ordinary communication for clearing
// - strict clear needs key; otherwise any write
//
// The Wishbone interface to the registers was chosen for this implementation.

`timescale 1ns/1ps

module comm_loss_watchdog
   import guard_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // host activity
   input wire logic comm_seen_i,
   input wire logic response_sent_i,
   // timeout actions
   output logic device_reset_o,
   output logic digital_update_o,
   output logic [31:0] digital_line_levels_o,
   output logic [31:0] digital_line_directions_o,
   output logic [31:0] digital_line_write_o,
   output logic analog0_load_o,
   output logic [31:0] analog0_value_o,
   output logic analog1_load_o,
   output logic [31:0] analog1_value_o,
   output logic load_factory_setup_o,
   output logic load_saved_setup_o,
   // interrupt
   output logic irq_o
);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [31:0] guard_enable, guard_advanced_options, guard_timeout_seconds;
   logic [31:0] guard_strict_enable, guard_strict_key, guard_reset_action;
   logic [31:0] guard_digital_action, guard_digital_level, guard_digital_direction;
   logic [31:0] guard_digital_mask, guard_analog0_action, guard_analog0_voltage;
   logic [31:0] guard_analog1_action, guard_analog1_voltage;
   logic [IRQ_W-1:0] irq_status, irq_mask;
   logic [31:0] next_guard_enable, next_guard_advanced_options, next_guard_timeout_seconds;
   logic [31:0] next_guard_strict_enable, next_guard_strict_key, next_guard_reset_action;
   logic [31:0] next_guard_digital_action, next_guard_digital_level, next_guard_digital_direction;
   logic [31:0] next_guard_digital_mask, next_guard_analog0_action, next_guard_analog0_voltage;
   logic [31:0] next_guard_analog1_action, next_guard_analog1_voltage;
   logic [IRQ_W-1:0] next_irq_status, next_irq_mask;
   logic [31:0] next_dat;
   logic next_ack, next_irq;

   // timer and sequencer state
   logic [31:0] div_count, sec_count, next_div_count, next_sec_count;
   seq_state_t state, next_state;
   logic next_device_reset, next_digital_update, next_analog0_load, next_analog1_load;
   logic next_load_factory, next_load_saved;
   logic [31:0] next_levels, next_directions, next_line_write, next_analog0_value, next_analog1_value;

   logic access, wr, rd;
   logic [IDX_W-1:0] idx;
   logic armed, strict, tick, clear_write, key_miss, clear_any, expire;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] lanes);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (lanes[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // one access per request; ack drops the cycle after it rises
   assign access = cyc_i && stb_i && !ack_o;
   assign wr = access && we_i;
   assign rd = access && !we_i;
   assign idx = adr_i[ADR_W-1:2];

   assign armed = (guard_enable == ACTION_ON);
   assign strict = (guard_strict_enable == ACTION_ON);
   // clear register acts whether or not armed; all other registers stay writable while armed
   assign clear_write = wr && (idx == IDX_STRICT_CLEAR) && (!strict || dat_i == guard_strict_key);
   assign key_miss = wr && (idx == IDX_STRICT_CLEAR) && strict && (dat_i != guard_strict_key);
   assign clear_any = clear_write || (!strict && (comm_seen_i || response_sent_i));
   assign tick = (div_count == 32'(TICK_LEN - 1));
   // timeout of 0 behaves as 1 second
   assign expire = armed && !clear_any && tick && ((sec_count + 32'h1) >= guard_timeout_seconds);

   // ------------------------------------------------------------
   // bus and registers
   // ------------------------------------------------------------
   // config is read live by the action logic, so the host must disarm first
   always_comb begin
      next_guard_enable = guard_enable;
      next_guard_advanced_options = guard_advanced_options;
      next_guard_timeout_seconds = guard_timeout_seconds;
      next_guard_strict_enable = guard_strict_enable;
      next_guard_strict_key = guard_strict_key;
      next_guard_reset_action = guard_reset_action;
      next_guard_digital_action = guard_digital_action;
      next_guard_digital_level = guard_digital_level;
      next_guard_digital_direction = guard_digital_direction;
      next_guard_digital_mask = guard_digital_mask;
      next_guard_analog0_action = guard_analog0_action;
      next_guard_analog0_voltage = guard_analog0_voltage;
      next_guard_analog1_action = guard_analog1_action;
      next_guard_analog1_voltage = guard_analog1_voltage;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      next_ack = access;
      next_dat = 32'h0000_0000;
      if (wr) begin
         unique case (idx)
            IDX_ENABLE: next_guard_enable = merge(guard_enable, dat_i, sel_i);
            IDX_ADVANCED: next_guard_advanced_options = merge(guard_advanced_options, dat_i, sel_i);
            IDX_TIMEOUT: next_guard_timeout_seconds = merge(guard_timeout_seconds, dat_i, sel_i);
            IDX_STRICT_ENABLE: next_guard_strict_enable = merge(guard_strict_enable, dat_i, sel_i);
            IDX_STRICT_KEY: next_guard_strict_key = merge(guard_strict_key, dat_i, sel_i);
            IDX_RESET_ACTION: next_guard_reset_action = merge(guard_reset_action, dat_i, sel_i);
            IDX_DIGITAL_ACTION: next_guard_digital_action = merge(guard_digital_action, dat_i, sel_i);
            IDX_DIGITAL_LEVEL: next_guard_digital_level = merge(guard_digital_level, dat_i, sel_i);
            IDX_DIGITAL_DIRECTION: next_guard_digital_direction = merge(guard_digital_direction, dat_i, sel_i);
            IDX_DIGITAL_MASK: next_guard_digital_mask = merge(guard_digital_mask, dat_i, sel_i);
            IDX_ANALOG0_ACTION: next_guard_analog0_action = merge(guard_analog0_action, dat_i, sel_i);
            IDX_ANALOG0_VOLTAGE: next_guard_analog0_voltage = merge(guard_analog0_voltage, dat_i, sel_i);
            IDX_ANALOG1_ACTION: next_guard_analog1_action = merge(guard_analog1_action, dat_i, sel_i);
            IDX_ANALOG1_VOLTAGE: next_guard_analog1_voltage = merge(guard_analog1_voltage, dat_i, sel_i);
            IDX_IRQ_MASK: next_irq_mask = sel_i[0] ? dat_i[IRQ_W-1:0] : irq_mask;
            IDX_IRQ_STATUS: begin
               if (sel_i[0]) begin
                  next_irq_status = irq_status & ~dat_i[IRQ_W-1:0];
               end
            end
            default: ;
         endcase
      end
      if (rd) begin
         unique case (idx)
            IDX_ENABLE: next_dat = guard_enable;
            IDX_ADVANCED: next_dat = guard_advanced_options;
            IDX_TIMEOUT: next_dat = guard_timeout_seconds;
            IDX_STRICT_ENABLE: next_dat = guard_strict_enable;
            IDX_STRICT_KEY: next_dat = guard_strict_key;
            IDX_RESET_ACTION: next_dat = guard_reset_action;
            IDX_DIGITAL_ACTION: next_dat = guard_digital_action;
            IDX_DIGITAL_LEVEL: next_dat = guard_digital_level;
            IDX_DIGITAL_DIRECTION: next_dat = guard_digital_direction;
            IDX_DIGITAL_MASK: next_dat = guard_digital_mask;
            IDX_ANALOG0_ACTION: next_dat = guard_analog0_action;
            IDX_ANALOG0_VOLTAGE: next_dat = guard_analog0_voltage;
            IDX_ANALOG1_ACTION: next_dat = guard_analog1_action;
            IDX_ANALOG1_VOLTAGE: next_dat = guard_analog1_voltage;
            IDX_IRQ_STATUS: next_dat = 32'(irq_status);
            IDX_IRQ_MASK: next_dat = 32'(irq_mask);
            IDX_STATE: next_dat = 32'({strict, armed});
            IDX_ELAPSED: next_dat = sec_count;
            default: next_dat = 32'h0000_0000;
         endcase
      end
      // a new event beats a simultaneous write-one-to-clear
      if (expire) begin
         next_irq_status[IRQ_TIMEOUT_BIT] = 1'b1;
      end
      if (key_miss) begin
         next_irq_status[IRQ_KEY_BIT] = 1'b1;
      end
      next_irq = |(next_irq_status & next_irq_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         guard_enable <= REG_RESET;
         guard_advanced_options <= REG_RESET;
         guard_timeout_seconds <= REG_RESET;
         guard_strict_enable <= REG_RESET;
         guard_strict_key <= REG_RESET;
         guard_reset_action <= REG_RESET;
         guard_digital_action <= REG_RESET;
         guard_digital_level <= REG_RESET;
         guard_digital_direction <= REG_RESET;
         guard_digital_mask <= REG_RESET;
         guard_analog0_action <= REG_RESET;
         guard_analog0_voltage <= REG_RESET;
         guard_analog1_action <= REG_RESET;
         guard_analog1_voltage <= REG_RESET;
         irq_status <= '0;
         irq_mask <= '0;
         ack_o <= 1'b0;
         dat_o <= REG_RESET;
         irq_o <= 1'b0;
      end else begin
         guard_enable <= next_guard_enable;
         guard_advanced_options <= next_guard_advanced_options;
         guard_timeout_seconds <= next_guard_timeout_seconds;
         guard_strict_enable <= next_guard_strict_enable;
         guard_strict_key <= next_guard_strict_key;
         guard_reset_action <= next_guard_reset_action;
         guard_digital_action <= next_guard_digital_action;
         guard_digital_level <= next_guard_digital_level;
         guard_digital_direction <= next_guard_digital_direction;
         guard_digital_mask <= next_guard_digital_mask;
         guard_analog0_action <= next_guard_analog0_action;
         guard_analog0_voltage <= next_guard_analog0_voltage;
         guard_analog1_action <= next_guard_analog1_action;
         guard_analog1_voltage <= next_guard_analog1_voltage;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         ack_o <= next_ack;
         dat_o <= next_dat;
         irq_o <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // seconds timer
   // ------------------------------------------------------------
   // clearing also restarts the divider so a period is always whole seconds
   always_comb begin
      next_div_count = div_count + 32'h1;
      next_sec_count = sec_count;
      if (!armed || clear_any || expire) begin
         next_div_count = 32'h0;
         next_sec_count = 32'h0;
      end else if (tick) begin
         next_div_count = 32'h0;
         next_sec_count = sec_count + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_count <= 32'h0;
         sec_count <= 32'h0;
      end else begin
         div_count <= next_div_count;
         sec_count <= next_sec_count;
      end
   end

   // ------------------------------------------------------------
   // timeout actions
   // ------------------------------------------------------------
   // i/o actions fire first; a reset one cycle later so they are seen before it
   always_comb begin
      next_state = state;
      next_device_reset = 1'b0;
      next_digital_update = 1'b0;
      next_analog0_load = 1'b0;
      next_analog1_load = 1'b0;
      next_load_factory = 1'b0;
      next_load_saved = 1'b0;
      next_levels = digital_line_levels_o;
      next_directions = digital_line_directions_o;
      next_line_write = digital_line_write_o;
      next_analog0_value = analog0_value_o;
      next_analog1_value = analog1_value_o;
      unique case (state)
         ST_IDLE: begin
            if (expire) begin
               if (guard_digital_action == ACTION_ON) begin
                  next_digital_update = 1'b1;
                  next_levels = guard_digital_level;
                  next_directions = guard_digital_direction;
                  next_line_write = ~guard_digital_mask;
               end
               if (guard_analog0_action == ACTION_ON) begin
                  next_analog0_load = 1'b1;
                  next_analog0_value = guard_analog0_voltage;
               end
               if (guard_analog1_action == ACTION_ON) begin
                  next_analog1_load = 1'b1;
                  next_analog1_value = guard_analog1_voltage;
               end
               next_load_factory = guard_advanced_options[ADV_FACTORY_BIT];
               next_load_saved = guard_advanced_options[ADV_SAVED_BIT];
               if (guard_reset_action == ACTION_ON) begin
                  next_state = ST_RESET;
               end
            end
         end
         ST_RESET: begin
            next_device_reset = 1'b1;
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         device_reset_o <= 1'b0;
         digital_update_o <= 1'b0;
         analog0_load_o <= 1'b0;
         analog1_load_o <= 1'b0;
         load_factory_setup_o <= 1'b0;
         load_saved_setup_o <= 1'b0;
         digital_line_levels_o <= REG_RESET;
         digital_line_directions_o <= REG_RESET;
         digital_line_write_o <= REG_RESET;
         analog0_value_o <= REG_RESET;
         analog1_value_o <= REG_RESET;
      end else begin
         state <= next_state;
         device_reset_o <= next_device_reset;
         digital_update_o <= next_digital_update;
         analog0_load_o <= next_analog0_load;
         analog1_load_o <= next_analog1_load;
         load_factory_setup_o <= next_load_factory;
         load_saved_setup_o <= next_load_saved;
         digital_line_levels_o <= next_levels;
         digital_line_directions_o <= next_directions;
         digital_line_write_o <= next_line_write;
         analog0_value_o <= next_analog0_value;
         analog1_value_o <= next_analog1_value;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking chk_clk @(posedge clk_i); endclocking
   default disable iff (rst_i);

   disarmed_idle_a: assert property (!armed |=> sec_count == 32'h0 && div_count == 32'h0)
      else $error("timer ran while disarmed");
   comm_clear_a: assert property (armed && !strict && comm_seen_i |=> div_count == 32'h0)
      else $error("communication did not clear timer");
   expire_point_a: assert property (expire |-> tick && sec_count + 32'h1 >= guard_timeout_seconds)
      else $error("expiry before timeout reached");
   resp_clear_a: assert property (armed && !strict && response_sent_i |=> sec_count == 32'h0)
      else $error("response did not restart timeout");
   reset_late_a: assert property (expire && guard_reset_action == ACTION_ON |=> !device_reset_o ##1 device_reset_o)
      else $error("reset not one cycle after i/o actions");
   digital_copy_a: assert property (expire && guard_digital_action == ACTION_ON |=>
      digital_update_o && digital_line_levels_o == $past(guard_digital_level))
      else $error("digital levels not applied");
   direction_copy_a: assert property (expire && guard_digital_action == ACTION_ON |=>
      digital_line_directions_o == $past(guard_digital_direction))
      else $error("digital directions not applied");
   mask_hold_a: assert property (digital_update_o |-> digital_line_write_o == ~$past(guard_digital_mask))
      else $error("masked lines written");
   analog0_load_a: assert property (expire && guard_analog0_action == ACTION_ON |=>
      analog0_load_o && analog0_value_o == $past(guard_analog0_voltage))
      else $error("analog 0 not loaded");
   analog1_load_a: assert property (analog1_load_o |-> $past(expire) && analog1_value_o == $past(guard_analog1_voltage))
      else $error("analog 1 load without expiry");
   factory_load_a: assert property (expire && guard_advanced_options[ADV_FACTORY_BIT] |=> load_factory_setup_o)
      else $error("factory reload missing");
   saved_load_a: assert property (load_saved_setup_o |-> $past(expire))
      else $error("saved reload without expiry");
   strict_ignore_a: assert property (armed && strict && !clear_write && !tick |=> sec_count == $past(sec_count))
      else $error("strict timer cleared without key");
   key_miss_a: assert property (key_miss |=> irq_status[IRQ_KEY_BIT] ##1 (irq_o || !irq_mask[IRQ_KEY_BIT]))
      else $error("key mismatch not flagged");

   timeout_reset_c: cover property (expire && guard_reset_action == ACTION_ON ##2 device_reset_o);
   strict_clear_c: cover property (strict && clear_write);
   key_miss_c: cover property (key_miss);
   irq_raise_c: cover property (!irq_o ##1 irq_o);

endmodule

// ==== host_activity_model.sv ====
// host-side traffic model: turns bench requests into activity pulses
// assumes one clock shared with the watchdog; pulses last one cycle

`timescale 1ns/1ps

module host_activity_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bench requests
   input wire logic talk_i,
   input wire logic answer_i,
   // pulses toward the watchdog
   output logic comm_seen_o,
   output logic response_sent_o
);
   // registered so the pulses never glitch on the edge the bench drives
   always_ff @(posedge clk_i) begin
      comm_seen_o <= !rst_i && talk_i;
      response_sent_o <= !rst_i && answer_i;
   end
endmodule

// ==== comm_loss_watchdog_test.sv ====
// self-checking bench for the communication-loss watchdog
// assumes a short tick of ten cycles and a two-second timeout

`timescale 1ns/1ps

module comm_loss_watchdog_test;
   import guard_pkg::*;
   localparam int TL = 10;
   logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, talk = 0, answer = 0;
   logic [ADR_W-1:0] adr_i = '0;
   logic [31:0] dat_i = '0, q;
   logic [3:0] sel_i = '0;
   logic ack_o, comm_seen, resp_sent, device_reset_o, digital_update_o, a0_ld, a1_ld, fac, sav, irq_o;
   logic [31:0] dat_o, lev, dir, wrm, a0_v, a1_v;
   int n_fail = 0, check_count = 0, cyc_n = 0, n;

   comm_loss_watchdog #(.TICK_LEN(TL)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
      .comm_seen_i(comm_seen), .response_sent_i(resp_sent), .device_reset_o(device_reset_o),
      .digital_update_o(digital_update_o), .digital_line_levels_o(lev), .digital_line_directions_o(dir),
      .digital_line_write_o(wrm), .analog0_load_o(a0_ld), .analog0_value_o(a0_v), .analog1_load_o(a1_ld),
      .analog1_value_o(a1_v), .load_factory_setup_o(fac), .load_saved_setup_o(sav), .irq_o(irq_o));
   host_activity_model i_host (.clk_i(clk_i), .rst_i(rst_i), .talk_i(talk), .answer_i(answer),
      .comm_seen_o(comm_seen), .response_sent_o(resp_sent));

   always #5 clk_i = ~clk_i;
   // ---------------------------------------------
   // hang guard
   // ---------------------------------------------
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 6000) begin
         n_fail++;
         final_report();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; waits for ack under a bound
   task wb(input logic w, input logic [IDX_W-1:0] idx, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {idx, 2'b00}; dat_i <= d; sel_i <= 4'hf;
      do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
      q = dat_o;
      cyc_i <= 0; stb_i <= 0; we_i <= 0;
      if (k == 50) chk(0, 1);
   endtask
   task rdc(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
      wb(0, idx, '0);
      chk(q, exp);
   endtask
   task wait_upd(input int lim);
      n = 0;
      while (digital_update_o !== 1'b1 && n < lim) begin @(posedge clk_i); n++; end
   endtask
   task quiet(input int len, input bit chat);
      for (int i = 0; i < len; i++) begin
         @(posedge clk_i);
         talk <= chat && (i % 12 == 0); answer <= chat && (i % 12 == 6);
         chk(digital_update_o, 0);
      end
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_regs;
      chk({ack_o, device_reset_o, digital_update_o, a0_ld, a1_ld, fac, sav, irq_o}, 0);
      chk(lev | dir | wrm | a0_v | a1_v | dat_o, 0);
      rdc(IDX_ENABLE, 32'h0);
      wb(1, IDX_DIGITAL_LEVEL, 32'ha5a5_0f0f);
      rdc(IDX_DIGITAL_LEVEL, 32'ha5a5_0f0f);
      rdc(16'hf0f0, 32'h0);
   endtask
   task t_expire;
      wb(1, IDX_ENABLE, 32'h0);
      wb(1, IDX_TIMEOUT, 32'h2); wb(1, IDX_RESET_ACTION, 32'h1); wb(1, IDX_DIGITAL_ACTION, 32'h1);
      wb(1, IDX_DIGITAL_LEVEL, 32'h1234_5678); wb(1, IDX_DIGITAL_DIRECTION, 32'h0000_ffff);
      wb(1, IDX_DIGITAL_MASK, 32'h0f00_00f0); wb(1, IDX_ANALOG0_ACTION, 32'h1);
      wb(1, IDX_ANALOG0_VOLTAGE, 32'h4020_0000); wb(1, IDX_ANALOG1_ACTION, 32'h1);
      wb(1, IDX_ANALOG1_VOLTAGE, 32'hc000_0000); wb(1, IDX_ADVANCED, 32'h3); wb(1, IDX_IRQ_MASK, 32'h1);
      quiet(30, 0);
      wb(1, IDX_ENABLE, 32'h1);
      wait_upd(2 * TL + 5);
      chk(n >= 2 * TL - 3 && n <= 2 * TL + 1, 1);
      chk(lev, 32'h1234_5678);
      chk(dir, 32'h0000_ffff);
      chk(wrm, 32'hf0ff_ff0f);
      chk(a0_ld, 1);
      chk(a0_v, 32'h4020_0000);
      chk(a1_ld, 1);
      chk(a1_v, 32'hc000_0000);
      chk({fac, sav}, 2'b11);
      chk(irq_o, 1);
      chk(device_reset_o, 0);
      @(posedge clk_i);
      chk({device_reset_o, digital_update_o}, 2'b10);
      rdc(IDX_IRQ_STATUS, 32'h1);
      wb(1, IDX_IRQ_STATUS, 32'h1);
      chk(irq_o, 0);
   endtask
   task t_strict;
      quiet(60, 1);
      wb(1, IDX_ENABLE, 32'h0);
      wb(1, IDX_STRICT_ENABLE, 32'h1); wb(1, IDX_STRICT_KEY, 32'h0000_c0de);
      wb(1, IDX_ENABLE, 32'h1);
      rdc(IDX_STATE, 32'h3);
      quiet(10, 0);
      talk <= 1; @(posedge clk_i); talk <= 0; answer <= 1; @(posedge clk_i); answer <= 0;
      wait_upd(2 * TL);
      chk(n < 12, 1);
      wb(1, IDX_STRICT_CLEAR, 32'h1);
      wb(0, IDX_IRQ_STATUS, '0);
      chk(q[1], 1);
      wb(1, IDX_ENABLE, 32'h0);
   endtask

   task final_report;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 0;
      t_regs();
      t_expire();
      t_strict();
      final_report();
   end
endmodule
